/* inc/cca_params.svh */
// timing, reset and field constants for the counter/compare array
// assumes inclusion by the package and by design modules
// What this block does
// - reading low count byte snapshots the high byte for the next high read
// - count byte reads never disturb counting
// - three-bit select picks tick: clk/12, clk/4, timer0, ext falling, clk, osc/8
// - external oscillator is synchronised to the system clock, then divided by eight
// - counter wrap from all ones to zero sets overflow flag
// - overflow request only when its enable is set; flag stays until cleared
// - requests recognised only with global and block interrupt enables set
// - idle-suspend bit set halts the block during cpu idle
// - rising and falling select bits choose capture transitions
// - valid transition copies counter to module register and sets module flag
// - capture input level valid only after two stable clocks
// - with comparator and match enables, equality sets module flag outside frequency and 8-bit pwm modes
// - compare low write clears comparator enable, high write sets it
// - toggle mode with match enable set inverts module line on each 16-bit match
// - frequency mode matches low bytes, toggles, adds high byte into low
// - frequency mode high byte zero gives 256 tick interval
// - 8-bit pwm: high on low-byte match, low on low-byte wrap unless the high byte is zero
// - 8-bit pwm reloads module low byte from high byte on wrap
// - 16-bit pwm: high on full match, low on counter overflow
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
`define CCA_DIV12        4'hb
`define CCA_DIV4         4'h3
`define CCA_OSC_DIV_TOP  3'h7
`define CCA_TB_DIV12     3'h0
`define CCA_TB_DIV4      3'h1
`define CCA_TB_T0        3'h2
`define CCA_TB_EXT       3'h3
`define CCA_TB_SYS       3'h4
`define CCA_TB_OSC8      3'h5
`define CCA_STABLE_CLKS  2'h2
`define CCA_COUNT_RESET  16'h0000
`define CCA_BYTE_RESET   8'h00
`endif

/* inc/cca_pkg.sv */
// types shared by the counter/compare array
// assumes cca_params.svh on the include path
`include "cca_params.svh"
package cca_pkg;
  typedef logic [15:0] cca_word_t;
  typedef logic [7:0]  cca_byte_t;
  typedef enum logic [2:0] {
    CCA_M_OFF, CCA_M_CAPT, CCA_M_TIMER, CCA_M_HSO, CCA_M_FREQ, CCA_M_PWM8, CCA_M_PWM16
  } cca_mode_e;
endpackage

/* verilog/cca_module.sv */
// one capture/compare module with its io line
// assumes counter and tick from the array, pin already synchronised
`timescale 1ns/100ps
module cca_module (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire cca_pkg::cca_word_t count,
  input  wire logic             tick,
  input  wire logic             low_wrap,
  input  wire logic             ovf,
  input  wire logic             line_sync,
  input  wire logic             rising_capture_sel,
  input  wire logic             falling_capture_sel,
  input  wire logic             match_flag_enable,
  input  wire logic             output_toggle_enable,
  input  wire logic             pulse_mod_enable,
  input  wire logic             wide_pulse_mod_select,
  input  wire logic             wr_low,
  input  wire logic             wr_high,
  input  wire cca_pkg::cca_byte_t wr_data,
  input  wire logic             flag_clear,
  output cca_pkg::cca_word_t    compare_value,
  output logic                  comparator_enable,
  output logic                  module_event_flag,
  output logic                  module_io_line
);
  import cca_pkg::*;
  typedef struct packed {
    logic [1:0] hist;
    logic       level;
    cca_byte_t  lo;
    cca_byte_t  hi;
    logic       ecom;
    logic       flag;
    logic       out;
  } cca_mod_s;
  cca_mod_s st;
  cca_mod_s next_st;
  logic     rise;
  logic     fall;
  logic     capt_on;
  logic     match16;
  logic     match8;
  cca_word_t nxt;
  logic     pwm_hit16;
  logic     pwm_hit8;
  always_comb begin
    next_st = st;
    // pwm edges follow the count value being entered
    nxt       = count + 16'h0001;
    pwm_hit16 = tick && ({st.hi, st.lo} == nxt);
    pwm_hit8  = tick && (st.lo == nxt[7:0]);
    capt_on = rising_capture_sel | falling_capture_sel;
    match16 = tick && ({st.hi, st.lo} == count);
    match8  = tick && (st.lo == count[7:0]);
    rise = 1'b0;
    fall = 1'b0;
    next_st.hist = {st.hist[0], line_sync};
    if (st.hist == {2{line_sync}} && line_sync != st.level) begin
      next_st.level = line_sync;
      rise = line_sync;
      fall = ~line_sync;
    end
    if (flag_clear) begin
      next_st.flag = 1'b0;
    end
    if (run) begin
      if (capt_on && !st.ecom && ((rise && rising_capture_sel) || (fall && falling_capture_sel))) begin
        next_st.lo   = count[7:0];
        next_st.hi   = count[15:8];
        next_st.flag = 1'b1;
      end
      if (st.ecom && pulse_mod_enable && output_toggle_enable) begin
        if (match8) begin
          next_st.out = ~st.out;
          next_st.lo  = st.lo + st.hi;
        end
      end else if (st.ecom && pulse_mod_enable && wide_pulse_mod_select) begin
        if (pwm_hit16) begin
          next_st.out = 1'b1;
        end else if (ovf) begin
          next_st.out = 1'b0;
        end
        if (pwm_hit16 && match_flag_enable) begin
          next_st.flag = 1'b1;
        end
      end else if (st.ecom && pulse_mod_enable) begin
        if (low_wrap) begin
          next_st.out = (st.hi == 8'h00);
          next_st.lo  = st.hi;
        end else if (pwm_hit8) begin
          next_st.out = 1'b1;
        end
      end else if (st.ecom && match16) begin
        if (match_flag_enable) begin
          next_st.flag = 1'b1;
        end
        if (output_toggle_enable && match_flag_enable) begin
          next_st.out = ~st.out;
        end
      end
    end
    if (wr_low) begin
      next_st.lo   = wr_data;
      next_st.ecom = 1'b0;
    end
    if (wr_high) begin
      next_st.hi   = wr_data;
      next_st.ecom = 1'b1;
    end
    if (rst) begin
      next_st = '0;
      next_st.level = 1'b1;
      next_st.hist  = 2'h3;
    end
  end
  always_ff @(posedge clk) begin
    st <= next_st;
  end
  assign compare_value     = {st.hi, st.lo};
  assign comparator_enable = st.ecom;
  assign module_event_flag = st.flag;
  assign module_io_line    = st.out;
  ecom_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_high |=> comparator_enable) else $error("high write did not enable comparator");
endmodule

/* verilog/cca_array.sv */
// counter array: 16-bit timebase counter and six capture/compare modules
// assumes pins asynchronous, control bits from the same clock domain
`timescale 1ns/100ps
module cca_array #(
  parameter int NUM_MODULES = 6
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    count_run_ctl,
  input  wire logic [2:0]              timebase_select,
  input  wire logic                    idle_suspend_ctl,
  input  wire logic                    cpu_idle,
  input  wire logic                    timer0_overflow,
  input  wire logic                    external_count_input,
  input  wire logic                    ext_osc_clock,
  input  wire logic                    overflow_irq_enable,
  input  wire logic                    global_irq_enable,
  input  wire logic                    array_irq_enable,
  input  wire logic                    overflow_flag_clear,
  input  wire logic                    count_low_read,
  input  wire logic                    count_high_read,
  input  wire logic [NUM_MODULES-1:0]  module_io_in,
  input  wire logic [NUM_MODULES-1:0]  module_irq_enable,
  input  wire logic [NUM_MODULES-1:0]  rising_capture_sel,
  input  wire logic [NUM_MODULES-1:0]  falling_capture_sel,
  input  wire logic [NUM_MODULES-1:0]  match_flag_enable,
  input  wire logic [NUM_MODULES-1:0]  output_toggle_enable,
  input  wire logic [NUM_MODULES-1:0]  pulse_mod_enable,
  input  wire logic [NUM_MODULES-1:0]  wide_pulse_mod_select,
  input  wire logic [NUM_MODULES-1:0]  module_compare_low_wr,
  input  wire logic [NUM_MODULES-1:0]  module_compare_high_wr,
  input  wire cca_pkg::cca_byte_t      wr_data,
  input  wire logic [NUM_MODULES-1:0]  module_flag_clear,
  output cca_pkg::cca_byte_t           count_read_data,
  output cca_pkg::cca_word_t           counter_array,
  output logic                         count_overflow_flag,
  output logic [NUM_MODULES-1:0]       module_event_flag,
  output logic [NUM_MODULES-1:0]       comparator_enable,
  output logic [NUM_MODULES-1:0]       module_io_line,
  output logic [16*NUM_MODULES-1:0]    module_compare_value,
  output logic                         irq_request
);
  import cca_pkg::*;
  typedef struct packed {
    logic [1:0]  ext_sync;
    logic [1:0]  osc_sync;
    logic        ext_prev;
    logic        osc_prev;
    logic [2:0]  osc_div;
    logic [3:0]  pre;
    cca_word_t   count;
    cca_byte_t   snap;
    cca_byte_t   rdata;
    logic        cf;
    logic [NUM_MODULES-1:0] io_s1;
    logic [NUM_MODULES-1:0] io_s2;
  } cca_top_s;
  cca_top_s st;
  cca_top_s next_st;
  logic     run;
  logic     tick;
  logic     ovf;
  logic     low_wrap;
  logic     pre_hit;
  logic [NUM_MODULES-1:0] flags;

  function automatic logic pre_wrap(input logic [3:0] p, input logic [3:0] top);
    pre_wrap = (p == top);
  endfunction

  always_comb begin
    next_st = st;
    run = count_run_ctl && !(cpu_idle && idle_suspend_ctl);
    next_st.ext_sync = {st.ext_sync[0], external_count_input};
    next_st.osc_sync = {st.osc_sync[0], ext_osc_clock};
    next_st.ext_prev = st.ext_sync[1];
    next_st.osc_prev = st.osc_sync[1];
    if (st.osc_sync[1] && !st.osc_prev) begin
      next_st.osc_div = st.osc_div + 3'h1;
    end
    next_st.io_s1 = module_io_in;
    next_st.io_s2 = st.io_s1;
    pre_hit = 1'b0;
    case (timebase_select)
      `CCA_TB_DIV12: pre_hit = pre_wrap(st.pre, `CCA_DIV12);
      `CCA_TB_DIV4:  pre_hit = pre_wrap(st.pre, `CCA_DIV4);
      `CCA_TB_T0:    pre_hit = timer0_overflow;
      `CCA_TB_EXT:   pre_hit = st.ext_prev && !st.ext_sync[1];
      `CCA_TB_SYS:   pre_hit = 1'b1;
      `CCA_TB_OSC8:  pre_hit = st.osc_sync[1] && !st.osc_prev && st.osc_div == `CCA_OSC_DIV_TOP;
      default:       pre_hit = 1'b0;
    endcase
    if (run) begin
      if (pre_hit || st.pre >= `CCA_DIV12) begin
        next_st.pre = 4'h0;
      end else begin
        next_st.pre = st.pre + 4'h1;
      end
    end
    tick     = run && pre_hit;
    ovf      = tick && (st.count == 16'hffff);
    low_wrap = tick && (st.count[7:0] == 8'hff);
    if (tick) begin
      next_st.count = st.count + 16'h0001;
    end
    if (count_low_read) begin
      next_st.snap  = st.count[15:8];
      next_st.rdata = st.count[7:0];
    end else if (count_high_read) begin
      next_st.rdata = st.snap;
    end
    if (overflow_flag_clear) begin
      next_st.cf = 1'b0;
    end
    if (ovf) begin
      next_st.cf = 1'b1;
    end
    if (rst) begin
      next_st = '0;
      next_st.count = `CCA_COUNT_RESET;
      next_st.snap  = `CCA_BYTE_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
    cca_module u_mod (
      .clk                   (clk),
      .rst                   (rst),
      .run                   (run),
      .count                 (st.count),
      .tick                  (tick),
      .low_wrap              (low_wrap),
      .ovf                   (ovf),
      .line_sync             (st.io_s2[i]),
      .rising_capture_sel    (rising_capture_sel[i]),
      .falling_capture_sel   (falling_capture_sel[i]),
      .match_flag_enable     (match_flag_enable[i]),
      .output_toggle_enable  (output_toggle_enable[i]),
      .pulse_mod_enable      (pulse_mod_enable[i]),
      .wide_pulse_mod_select (wide_pulse_mod_select[i]),
      .wr_low                (module_compare_low_wr[i]),
      .wr_high               (module_compare_high_wr[i]),
      .wr_data               (wr_data),
      .flag_clear            (module_flag_clear[i]),
      .compare_value         (module_compare_value[16*i +: 16]),
      .comparator_enable     (comparator_enable[i]),
      .module_event_flag     (flags[i]),
      .module_io_line        (module_io_line[i])
    );
  end

  assign module_event_flag   = flags;
  assign counter_array       = st.count;
  assign count_read_data     = st.rdata;
  assign count_overflow_flag = st.cf;
  assign irq_request = global_irq_enable && array_irq_enable &&
                       ((st.cf && overflow_irq_enable) || |(flags & module_irq_enable));

  overflow_flag_a: assert property (@(posedge clk) disable iff (rst)
    (tick && counter_array == 16'hffff) |=> (count_overflow_flag && counter_array == 16'h0000))
    else $error("wrap did not set overflow flag");
  snapshot_read_a: assert property (@(posedge clk) disable iff (rst)
    count_low_read ##1 (count_high_read && !count_low_read) |=>
    count_read_data == $past(counter_array[15:8], 2))
    else $error("high read lost snapshot");
  count_hold_a: assert property (@(posedge clk) disable iff (rst)
    !count_run_ctl |=> counter_array == $past(counter_array))
    else $error("counter moved while stopped");
  sys_tick_a: assert property (@(posedge clk) disable iff (rst)
    (count_run_ctl && !cpu_idle && timebase_select == `CCA_TB_SYS) |=>
    counter_array == $past(counter_array) + 16'h0001)
    else $error("sys timebase not counting");
  irq_gate_a: assert property (@(posedge clk) disable iff (rst)
    irq_request |-> (global_irq_enable && array_irq_enable))
    else $error("irq without enables");
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    (count_overflow_flag && !overflow_flag_clear) |=> count_overflow_flag)
    else $error("overflow flag dropped");
  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    (cpu_idle && idle_suspend_ctl) |=> counter_array == $past(counter_array))
    else $error("counted in idle");
  read_count_a: assert property (@(posedge clk) disable iff (rst)
    ((count_low_read || count_high_read) && count_run_ctl && !cpu_idle &&
     timebase_select == `CCA_TB_SYS) |=> counter_array == $past(counter_array) + 16'h0001)
    else $error("read changed counter");
endmodule

/* tb/cca_pin_model.sv */
// pin side model: capture pins, external count input, external oscillator
// assumes the bench requests capture pin levels at the falling clock edge
`timescale 1ns/100ps
module cca_pin_model (
  input  wire logic       clk,
  input  wire logic [5:0] pin_req,
  output logic [5:0]      module_io_in,
  output logic            external_count_input,
  output logic            ext_osc_clock
);
  logic [1:0] div_cnt;
  initial begin
    module_io_in = 6'h3f;
    external_count_input = 1'b1;
    ext_osc_clock = 1'b0;
    div_cnt = 2'h0;
  end
  always @(posedge clk) module_io_in <= pin_req;
  // count input four clocks high, four low
  always @(posedge clk) begin
    div_cnt <= div_cnt + 2'h1;
    if (div_cnt == 2'h3) external_count_input <= ~external_count_input;
  end
  // oscillator period 300 ns, slower than clk
  initial begin
    #37;
    forever #150 ext_osc_clock = ~ext_osc_clock;
  end
endmodule

/* tb/counter_capture_compare_array_bench.sv */
// self-checking bench for the counter/compare array
// assumes cca_pkg compiled first and the pin model beside it
`timescale 1ns/100ps
module counter_capture_compare_array_bench;
  import cca_pkg::*;
  logic clk, rst, count_run_ctl, idle_suspend_ctl, cpu_idle, timer0_overflow;
  logic overflow_irq_enable, global_irq_enable, array_irq_enable, overflow_flag_clear;
  logic count_low_read, count_high_read, external_count_input, ext_osc_clock;
  logic count_overflow_flag, irq_request;
  logic [2:0] timebase_select;
  logic [5:0] pin_req, module_io_in, module_irq_enable, rising_capture_sel;
  logic [5:0] falling_capture_sel, match_flag_enable, output_toggle_enable;
  logic [5:0] pulse_mod_enable, wide_pulse_mod_select, module_compare_low_wr;
  logic [5:0] module_compare_high_wr, module_flag_clear, module_event_flag;
  logic [5:0] comparator_enable, module_io_line, prev;
  logic [95:0] module_compare_value;
  cca_byte_t wr_data, count_read_data, d;
  cca_word_t counter_array, cap;
  int failures, checks_done, cycles, hi8, hi16, tg1, tg2;
  int tb_exp [8] = '{20, 60, 60, 30, 240, 10, 0, 0};
  cca_word_t cmpv [5] = '{16'h0100, 16'h1234, 16'h0400, 16'hc000, 16'hffc0};

  cca_array #(.NUM_MODULES(6)) DUT (.clk, .rst, .count_run_ctl, .timebase_select,
    .idle_suspend_ctl, .cpu_idle, .timer0_overflow, .external_count_input, .ext_osc_clock,
    .overflow_irq_enable, .global_irq_enable, .array_irq_enable, .overflow_flag_clear,
    .count_low_read, .count_high_read, .module_io_in, .module_irq_enable,
    .rising_capture_sel, .falling_capture_sel, .match_flag_enable, .output_toggle_enable,
    .pulse_mod_enable, .wide_pulse_mod_select, .module_compare_low_wr,
    .module_compare_high_wr, .wr_data, .module_flag_clear, .count_read_data,
    .counter_array, .count_overflow_flag, .module_event_flag, .comparator_enable,
    .module_io_line, .module_compare_value, .irq_request);
  cca_pin_model pins (.clk, .pin_req, .module_io_in, .external_count_input,
    .ext_osc_clock);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) timer0_overflow <= (cycles % 4 == 0);
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_cmp(input int m, input logic hi, input cca_byte_t v);
    wr_data = v;
    if (hi) module_compare_high_wr[m] = 1'b1;
    else module_compare_low_wr[m] = 1'b1;
    tick(1);
    module_compare_low_wr = 6'h00;
    module_compare_high_wr = 6'h00;
    tick(1);
  endtask
  task automatic rd(input logic hi, output cca_byte_t v);
    if (hi) count_high_read = 1'b1;
    else count_low_read = 1'b1;
    tick(1);
    count_low_read = 1'b0;
    count_high_read = 1'b0;
    v = count_read_data;
  endtask
  task automatic delta(input logic [2:0] sel, input int n, input int exp);
    cca_word_t a;
    timebase_select = sel;
    tick(30);
    a = counter_array;
    tick(n);
    chk(exp, cca_word_t'(counter_array - a));
  endtask

  initial begin
    {count_run_ctl, idle_suspend_ctl, cpu_idle, timer0_overflow, overflow_irq_enable} = '0;
    {global_irq_enable, array_irq_enable, overflow_flag_clear} = '0;
    {count_low_read, count_high_read, module_irq_enable, rising_capture_sel} = '0;
    {falling_capture_sel, match_flag_enable, output_toggle_enable, pulse_mod_enable} = '0;
    {wide_pulse_mod_select, module_compare_low_wr, module_compare_high_wr} = '0;
    {module_flag_clear, wr_data, timebase_select} = '0;
    {failures, checks_done, cycles, hi8, hi16, tg1, tg2} = '0;
    pin_req = 6'h3f;
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    tick(10);
    chk(0, counter_array);
    count_run_ctl = 1'b1;
    for (int i = 0; i < 8; i++) delta(3'(i), 240, tb_exp[i]);
    count_run_ctl = 1'b0;
    delta(3'h4, 240, 0);
    count_run_ctl = 1'b1;
    $display("test timebase done");
    cpu_idle = 1'b1;
    idle_suspend_ctl = 1'b1;
    delta(3'h4, 240, 0);
    idle_suspend_ctl = 1'b0;
    delta(3'h4, 240, 240);
    cpu_idle = 1'b0;
    $display("test idle done");
    cap = counter_array;
    rd(1'b0, d);
    chk(cap[7:0], d);
    tick(298);
    rd(1'b1, d);
    chk(cap[15:8], d);
    chk(300, cca_word_t'(counter_array - cap));
    cap = counter_array;
    rd(1'b0, d);
    rd(1'b1, d);
    chk(cap[15:8], d);
    $display("test read done");
    timebase_select = 3'h6;
    tick(5);
    cap = counter_array;
    rising_capture_sel[5] = 1'b1;
    pin_req[5] = 1'b0;
    tick(10);
    chk(0, module_event_flag[5]);
    pin_req[5] = 1'b1;
    tick(10);
    chk(1, module_event_flag[5]);
    chk(cap, module_compare_value[95:80]);
    module_flag_clear[5] = 1'b1;
    tick(1);
    module_flag_clear = 6'h00;
    falling_capture_sel[5] = 1'b1;
    pin_req[5] = 1'b0;
    tick(10);
    chk(1, module_event_flag[5]);
    $display("test capture done");
    match_flag_enable = 6'h03;
    output_toggle_enable = 6'h06;
    pulse_mod_enable = 6'h1c;
    wide_pulse_mod_select = 6'h10;
    wr_cmp(0, 1'b1, 8'h01);
    wr_cmp(0, 1'b0, 8'h00);
    chk(0, comparator_enable[0]);
    wr_cmp(0, 1'b1, 8'h01);
    chk(1, comparator_enable[0]);
    chk(cmpv[0], module_compare_value[15:0]);
    for (int m = 1; m < 5; m++) begin
      wr_cmp(m, 1'b0, cmpv[m][7:0]);
      wr_cmp(m, 1'b1, cmpv[m][15:8]);
    end
    count_run_ctl = 1'b1;
    timebase_select = 3'h4;
    tick(600);
    overflow_flag_clear = 1'b1;
    module_flag_clear = 6'h3f;
    tick(1);
    overflow_flag_clear = 1'b0;
    module_flag_clear = 6'h00;
    prev = module_io_line;
    for (int i = 0; i < 65536; i++) begin
      tick(1);
      hi16 += module_io_line[4];
      hi8 += module_io_line[3];
      tg1 += module_io_line[1] ^ prev[1];
      tg2 += module_io_line[2] ^ prev[2];
      prev = module_io_line;
    end
    chk(64, hi16);
    chk(16384, hi8);
    chk(1, tg1);
    chk(16384, tg2);
    chk(1, count_overflow_flag);
    chk(1, module_event_flag[0]);
    $display("test waveforms done");
    overflow_irq_enable = 1'b1;
    global_irq_enable = 1'b1;
    tick(1);
    chk(0, irq_request);
    array_irq_enable = 1'b1;
    tick(1);
    chk(1, irq_request);
    overflow_irq_enable = 1'b0;
    tick(1);
    chk(0, irq_request);
    module_irq_enable = 6'h01;
    tick(1);
    chk(1, irq_request);
    chk(1, count_overflow_flag);
    overflow_flag_clear = 1'b1;
    tick(1);
    overflow_flag_clear = 1'b0;
    tick(1);
    chk(0, count_overflow_flag);
    $display("test interrupts done");
    summarize();
  end
endmodule
